// ==== dpsram_host_pkg.sv ====
package dpsram_host_pkg;
  // ----------------------------------------------------------------
  // clock, timing, widths and lane codes
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int T_PWE_NS = 10;
  localparam int T_HZWE_NS = 10;
  localparam int T_SD_NS = 10;
  localparam int T_SOP_NS = 10;
  localparam int T_SWRD_NS = 5;
  localparam int T_DOE_NS = 8;
  localparam int T_WH_NS = 11;
  localparam int T_BLA_NS = 12;
  localparam int T_RC_NS = 12;
  localparam int T_SETTLE_NS = 12;
  // a pin level reaches the logic only after the four-flop synchroniser
  localparam int SYNC_CYC = 4;
  // least times round up to whole cycles, never below one
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ns_to_cyc
  localparam int PULSE_PLAIN_CYC = ns_to_cyc(T_PWE_NS);
  localparam int PULSE_OE_CYC = ns_to_cyc((T_PWE_NS > T_HZWE_NS + T_SD_NS) ?
                                           T_PWE_NS : (T_HZWE_NS + T_SD_NS));
  localparam int TOKEN_UPDATE_CYC = ns_to_cyc(T_SOP_NS);
  localparam int TOKEN_WR_RD_CYC = ns_to_cyc(T_SWRD_NS + T_DOE_NS);
  localparam int WH_CYC = ns_to_cyc(T_WH_NS);
  localparam int FLAG_SETTLE_CYC = ns_to_cyc(T_BLA_NS);
  localparam int ACCESS_CYC = ns_to_cyc(T_RC_NS);
  localparam int POWERUP_CYC = ns_to_cyc(T_RC_NS) + 1;
  localparam int CNT_W = 8;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 36;
  localparam int LANE_W = 4;
  localparam int TOKEN_ADDR_W = 3;
  localparam logic [LANE_W-1:0] LANES_OFF = 4'hf;
  localparam logic [LANE_W-1:0] LANES_ALL = 4'h0;
endpackage : dpsram_host_pkg

// ==== pin_sync.sv ====
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] lvl;
  } sync_type;
  sync_type cur_ff;
  sync_type nxt_ff;
  if (WIDTH < 1) begin : g_bad_width
    $error("pin_sync width must be positive");
  end
  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.s1 = pin_i;
    nxt_ff.s2 = cur_ff.s1;
    nxt_ff.s3 = cur_ff.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (cur_ff.s2[i] == cur_ff.s3[i]) begin
        nxt_ff.lvl[i] = cur_ff.s3[i];
      end
    end
  end
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cur_ff <= '{s1: '1, s2: '1, s3: '1, lvl: '1};
    end else begin
      cur_ff <= nxt_ff;
    end
  end
  assign level_o = cur_ff.lvl;
endmodule : pin_sync

// ==== dpsram_host.sv ====
module dpsram_host
  import dpsram_host_pkg::*;
#(
  parameter int ADDR_WIDTH = dpsram_host_pkg::ADDR_W,
  parameter int DATA_WIDTH = dpsram_host_pkg::DATA_W
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic req_i,
  input wire logic req_write_i,
  input wire logic req_token_i,
  input wire logic [ADDR_WIDTH-1:0] req_addr_i,
  input wire logic [DATA_WIDTH-1:0] req_wdata_i,
  input wire logic [dpsram_host_pkg::LANE_W-1:0] req_lanes_n_i,
  input wire logic retention_i,
  input wire logic slave_role_i,
  output logic busy_o,
  output logic done_o,
  output logic [DATA_WIDTH-1:0] rdata_o,
  output logic mailbox_irq_o,
  output logic [ADDR_WIDTH-1:0] addr_o,
  output logic primary_select_n_o,
  output logic secondary_select_o,
  output logic token_select_n_o,
  output logic write_strobe_n_o,
  output logic output_gate_n_o,
  output logic [dpsram_host_pkg::LANE_W-1:0] lane_select_n_o,
  output logic [DATA_WIDTH-1:0] data_o,
  output logic data_oe_o,
  input wire logic [DATA_WIDTH-1:0] data_i,
  input wire logic contention_n_i,
  input wire logic interrupt_n_i
);
  import dpsram_host_pkg::*;

  if (ADDR_WIDTH < TOKEN_ADDR_W || DATA_WIDTH < 1) begin : g_bad_widths
    $error("dpsram_host bad widths");
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [DATA_WIDTH+1:0] pins_lvl;
  logic [DATA_WIDTH-1:0] rd_pins;
  logic cont_n;
  logic irq_n;
  pin_sync #(.WIDTH(DATA_WIDTH + 2)) u_sync (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .pin_i({contention_n_i, interrupt_n_i, data_i}),
    .level_o(pins_lvl)
  );
  assign rd_pins = pins_lvl[DATA_WIDTH-1:0];
  assign irq_n = pins_lvl[DATA_WIDTH];
  assign cont_n = pins_lvl[DATA_WIDTH+1];

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_POWERUP, ST_IDLE, ST_SETUP, ST_SETTLE, ST_PULSE, ST_READ, ST_RECOVER
  } state_type;

  typedef struct packed {
    state_type st;
    logic [CNT_W-1:0] cnt;
    logic wr;
    logic tok;
    logic busy;
    logic done;
    logic [DATA_WIDTH-1:0] rdata;
    logic irq;
    logic [ADDR_WIDTH-1:0] addr;
    logic psel_n;
    logic ssel;
    logic tsel_n;
    logic we_n;
    logic oe_n;
    logic [LANE_W-1:0] lanes_n;
    logic [DATA_WIDTH-1:0] dout;
    logic doe;
    logic tok_pending;
  } host_type;

  host_type cur_ff;
  host_type nxt_ff;

  function automatic logic [CNT_W-1:0] cyc(input int n);
    return CNT_W'(n);
  endfunction : cyc

  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.done = 1'b0;
    nxt_ff.irq = ~irq_n;
    if (cur_ff.cnt != '0) nxt_ff.cnt = cur_ff.cnt - cyc(1);
    case (cur_ff.st)
      ST_POWERUP: begin
        if (cur_ff.cnt == '0) begin
          nxt_ff.st = ST_IDLE;
          nxt_ff.busy = 1'b0;
        end
      end
      ST_IDLE: begin
        nxt_ff.psel_n = 1'b1;
        nxt_ff.tsel_n = 1'b1;
        if (req_i && !retention_i && cur_ff.cnt == '0) begin
          nxt_ff.busy = 1'b1;
          nxt_ff.wr = req_write_i;
          nxt_ff.tok = req_token_i;
          // address moves only while the strobe is high
          nxt_ff.addr = req_addr_i;
          nxt_ff.lanes_n = req_token_i ? LANES_ALL : req_lanes_n_i;
          nxt_ff.dout = req_wdata_i;
          nxt_ff.st = ST_SETUP;
        end
      end
      ST_SETUP: begin
        // select exactly one of array or token before the strobe
        nxt_ff.psel_n = cur_ff.tok;
        nxt_ff.ssel = 1'b1;
        nxt_ff.tsel_n = ~cur_ff.tok;
        nxt_ff.oe_n = cur_ff.wr; // gate high on writes keeps the short pulse
        nxt_ff.cnt = cyc(FLAG_SETTLE_CYC);
        nxt_ff.st = cur_ff.wr ? ST_SETTLE : ST_READ;
        // read capture waits out the synchroniser, else it takes the old word
        if (!cur_ff.wr && cur_ff.tok && cur_ff.tok_pending) begin
          nxt_ff.cnt = cyc(TOKEN_WR_RD_CYC + SYNC_CYC);
        end else if (!cur_ff.wr) begin
          nxt_ff.cnt = cyc(ACCESS_CYC + SYNC_CYC);
        end
      end
      ST_SETTLE: begin
        // slave: strobe waits for a settled and released flag
        if (cur_ff.cnt == '0 && (!slave_role_i || cont_n)) begin
          nxt_ff.we_n = 1'b0;
          nxt_ff.doe = 1'b1;
          nxt_ff.cnt = cur_ff.oe_n ? cyc(PULSE_PLAIN_CYC) : cyc(PULSE_OE_CYC);
          nxt_ff.st = ST_PULSE;
        end
      end
      ST_PULSE: begin
        if (slave_role_i && !cont_n) begin
          // flag came back: hold strobe high and retry after release
          nxt_ff.we_n = 1'b1;
          nxt_ff.cnt = cyc(WH_CYC);
          nxt_ff.st = ST_SETTLE;
        end else if (cur_ff.cnt == '0) begin
          nxt_ff.we_n = 1'b1;
          nxt_ff.st = ST_RECOVER;
          nxt_ff.tok_pending = cur_ff.tok;
          nxt_ff.cnt = cur_ff.tok ? cyc(TOKEN_UPDATE_CYC) : cyc(1);
        end
      end
      ST_READ: begin
        if (cur_ff.cnt == '0) begin
          nxt_ff.rdata = rd_pins;
          if (cur_ff.tok) nxt_ff.tok_pending = 1'b0;
          nxt_ff.st = ST_RECOVER;
          nxt_ff.cnt = cyc(1);
        end
      end
      ST_RECOVER: begin
        nxt_ff.doe = 1'b0;
        nxt_ff.oe_n = 1'b1;
        nxt_ff.psel_n = 1'b1;
        nxt_ff.tsel_n = 1'b1;
        if (!cur_ff.we_n) nxt_ff.we_n = 1'b1;
        nxt_ff.done = 1'b1;
        nxt_ff.busy = 1'b0;
        nxt_ff.st = ST_IDLE;
      end
      default: nxt_ff.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cur_ff <= '{st: ST_POWERUP, cnt: CNT_W'(POWERUP_CYC), busy: 1'b1,
                  psel_n: 1'b1, tsel_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
                  lanes_n: LANES_OFF, default: '0};
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign busy_o = cur_ff.busy;
  assign done_o = cur_ff.done;
  assign rdata_o = cur_ff.rdata;
  assign mailbox_irq_o = cur_ff.irq;
  assign addr_o = cur_ff.addr;
  assign primary_select_n_o = cur_ff.psel_n;
  assign secondary_select_o = cur_ff.ssel;
  assign token_select_n_o = cur_ff.tsel_n;
  assign write_strobe_n_o = cur_ff.we_n;
  assign output_gate_n_o = cur_ff.oe_n;
  assign lane_select_n_o = cur_ff.lanes_n;
  assign data_o = cur_ff.dout;
  assign data_oe_o = cur_ff.doe;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_select_exclusive: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    !write_strobe_n_o |-> (primary_select_n_o != token_select_n_o))
    else $error("write with both or neither select");
  chk_read_strobe: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (!output_gate_n_o) |-> write_strobe_n_o)
    else $error("strobe low while reading");
  chk_addr_stable: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    $changed(addr_o) |-> (write_strobe_n_o && $past(write_strobe_n_o)))
    else $error("address moved under strobe");
  chk_pulse_width: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    ($fell(write_strobe_n_o) && !slave_role_i) |-> !write_strobe_n_o [*2])
    else $error("write pulse too short");
  chk_token_gap: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    ($rose(write_strobe_n_o) && !token_select_n_o) |=> token_select_n_o)
    else $error("token not deselected after write");
  chk_retention: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (retention_i && !busy_o) |=> primary_select_n_o)
    else $error("select active during retention");
  chk_powerup: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    $rose(reset_n_i) |-> primary_select_n_o [*2])
    else $error("access too soon after power-up");
  chk_slave_flag: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    ($fell(write_strobe_n_o) && slave_role_i) |-> $past(cont_n))
    else $error("strobe fell under contention flag");
endmodule : dpsram_host

// ==== dpsram_dev_model.sv ====
module dpsram_dev_model
  import dpsram_host_pkg::*;
(
  input wire logic mclk_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic primary_select_n_i,
  input wire logic secondary_select_i,
  input wire logic token_select_n_i,
  input wire logic write_strobe_n_i,
  input wire logic output_gate_n_i,
  input wire logic [LANE_W-1:0] lane_select_n_i,
  input wire logic [DATA_W-1:0] data_i,
  input wire logic contend_i,
  input wire logic other_mbox_i,
  input wire logic [7:0] other_token_i,
  output logic [DATA_W-1:0] data_o,
  output logic contention_n_o,
  output logic interrupt_n_o,
  output logic [7:0] viol_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // one port of the memory, seen from the host
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] mem [int];
  logic [DATA_W-1:0] last = '0;
  logic [DATA_W-1:0] rd_val;
  logic [ADDR_W-1:0] prev_addr = '0;
  logic [7:0] own = 8'h0;
  logic irq = 1'b0;
  logic prev_we = 1'b1;
  logic ram_sel, tok_sel, rd_en;
  initial viol_o = 8'h0;
  assign ram_sel = !primary_select_n_i && secondary_select_i && token_select_n_i;
  assign tok_sel = !token_select_n_i && (primary_select_n_i || !secondary_select_i);
  assign rd_en = (ram_sel || tok_sel) && write_strobe_n_i && !output_gate_n_i;
  // released lines show the inverse, so a stale word never passes for data
  assign data_o = rd_en ? rd_val : ~last;
  assign contention_n_o = !contend_i;
  assign interrupt_n_o = !irq;
  always @* begin
    if (tok_sel) rd_val = {35'h0, !own[addr_i[2:0]]};
    else if (mem.exists(addr_i)) rd_val = mem[addr_i];
    else rd_val = '0;
  end
  always @(posedge mclk_i) begin
    if (rd_en) last <= rd_val;
    prev_addr <= addr_i;
    prev_we <= write_strobe_n_i;
    if ((addr_i != prev_addr && !(write_strobe_n_i && prev_we)) ||
        (!primary_select_n_i && secondary_select_i && !token_select_n_i) ||
        (prev_we && !write_strobe_n_i && contend_i)) viol_o <= viol_o + 8'h1;
    if (!write_strobe_n_i && ram_sel) begin
      if (!mem.exists(addr_i)) mem[addr_i] = '0;
      for (int j = 0; j < LANE_W; j++) begin
        if (!lane_select_n_i[j]) mem[addr_i][9 * j +: 9] = data_i[9 * j +: 9];
      end
    end
    // update lags the strobe so an early read sees the old state
    if (!write_strobe_n_i && tok_sel) begin
      if (data_i[0]) own[addr_i[2:0]] <= #5 1'b0;
      else if (!other_token_i[addr_i[2:0]]) own[addr_i[2:0]] <= #5 1'b1;
    end
    if (other_mbox_i) irq <= 1'b1;
    else if (rd_en && ram_sel && addr_i == 15'h7ffe) irq <= 1'b0;
  end
endmodule : dpsram_dev_model

// ==== dpsram_host_test.sv ====
module dpsram_host_test;
  timeunit 1ns;
  timeprecision 1ps;
  import dpsram_host_pkg::*;
  // ----------------------------------------------------------------
  // bench
  // ----------------------------------------------------------------
  typedef struct packed {logic care; logic [DATA_W-1:0] val;} note_type;
  logic mclk_i, reset_n_i, req_i, req_write_i, req_token_i, retention_i, slave_role_i;
  logic busy_o, done_o, mailbox_irq_o, primary_select_n_o, secondary_select_o;
  logic token_select_n_o, write_strobe_n_o, output_gate_n_o, data_oe_o;
  logic contention_n_i, interrupt_n_i, contend, other_mbox;
  logic [ADDR_W-1:0] req_addr_i, addr_o;
  logic [LANE_W-1:0] req_lanes_n_i, lane_select_n_o, ln;
  logic [DATA_W-1:0] req_wdata_i, rdata_o, data_o, data_i, w, e;
  logic [7:0] other_tok, viol;
  logic [ADDR_W-1:0] a [6];
  logic [DATA_W-1:0] d [6];
  note_type notes[$];
  note_type n;
  int mismatches = 0;
  int num_checks = 0;
  dpsram_host uut (
    .mclk_i, .reset_n_i, .req_i, .req_write_i, .req_token_i, .req_addr_i, .req_wdata_i,
    .req_lanes_n_i, .retention_i, .slave_role_i, .busy_o, .done_o, .rdata_o, .mailbox_irq_o,
    .addr_o, .primary_select_n_o, .secondary_select_o, .token_select_n_o, .write_strobe_n_o,
    .output_gate_n_o, .lane_select_n_o, .data_o, .data_oe_o, .data_i, .contention_n_i,
    .interrupt_n_i
  );
  dpsram_dev_model dev (
    .mclk_i, .addr_i(addr_o), .primary_select_n_i(primary_select_n_o),
    .secondary_select_i(secondary_select_o), .token_select_n_i(token_select_n_o),
    .write_strobe_n_i(write_strobe_n_o), .output_gate_n_i(output_gate_n_o),
    .lane_select_n_i(lane_select_n_o), .data_i(data_o), .data_o(data_i), .contend_i(contend),
    .other_mbox_i(other_mbox), .other_token_i(other_tok), .contention_n_o(contention_n_i),
    .interrupt_n_o(interrupt_n_i), .viol_o(viol)
  );
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  task automatic xfer(input logic wr, input logic tok, input logic [ADDR_W-1:0] ad,
                      input logic [DATA_W-1:0] wd, input logic [LANE_W-1:0] lanes,
                      input logic care, input logic [DATA_W-1:0] exp);
    int k;
    k = 0;
    while (busy_o !== 1'b0 && k < 300) begin
      @(negedge mclk_i);
      k++;
    end
    notes.push_back('{care, exp});
    req_write_i = wr;
    req_token_i = tok;
    req_addr_i = ad;
    req_wdata_i = wd;
    req_lanes_n_i = lanes;
    req_i = 1'b1;
    @(negedge mclk_i);
    req_i = 1'b0;
    k = 0;
    while (done_o !== 1'b1 && k < 300) begin
      @(negedge mclk_i);
      k++;
    end
    if (k == 300) mismatches++;
  endtask : xfer
  always @(negedge mclk_i) begin
    if (done_o === 1'b1) begin
      if (notes.size() > 0) n = notes.pop_front();
      else n = '{1'b1, ~rdata_o};
      if (n.care) chk(rdata_o, n.val);
    end
  end
  initial begin
    mclk_i = 1'b0;
    forever #(CLK_PERIOD_NS / 2) mclk_i = ~mclk_i;
  end
  initial begin
    #(CLK_PERIOD_NS * 20000);
    mismatches++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'hd4b6ab27));
    {reset_n_i, req_i, req_write_i, req_token_i, retention_i, slave_role_i} = 6'h0;
    {contend, other_mbox} = 2'h0;
    other_tok = 8'h20;
    req_addr_i = '0;
    req_wdata_i = '0;
    req_lanes_n_i = LANES_ALL;
    repeat (5) @(negedge mclk_i);
    chk(36'({primary_select_n_o, token_select_n_o, write_strobe_n_o, data_oe_o}), 36'he);
    reset_n_i = 1'b1;
    @(negedge mclk_i);
    chk(36'(busy_o), 36'h1);
    for (int i = 0; i < 6; i++) begin
      a[i] = 15'(i * 977 + $urandom_range(0, 900));
      d[i] = {4'($urandom), $urandom};
      xfer(1'b1, 1'b0, a[i], d[i], LANES_ALL, 1'b0, '0);
    end
    for (int i = 0; i < 6; i++) xfer(1'b0, 1'b0, a[i], '0, LANES_ALL, 1'b1, d[i]);
    for (int i = 0; i < 4; i++) begin
      w = {4'($urandom), $urandom};
      ln = 4'($urandom_range(1, 14));
      e = d[i];
      for (int j = 0; j < LANE_W; j++) if (!ln[j]) e[9 * j +: 9] = w[9 * j +: 9];
      xfer(1'b1, 1'b0, a[i], w, ln, 1'b0, '0);
      xfer(1'b0, 1'b0, a[i], '0, LANES_ALL, 1'b1, e);
    end
    for (int t = 0; t < 8; t++) begin
      xfer(1'b1, 1'b1, 15'(t), 36'h0, LANES_ALL, 1'b0, '0);
      xfer(1'b0, 1'b1, 15'(t), '0, LANES_ALL, 1'b1, 36'(other_tok[t]));
      xfer(1'b1, 1'b1, 15'(t), 36'h1, LANES_ALL, 1'b0, '0);
      xfer(1'b0, 1'b1, 15'(t), '0, LANES_ALL, 1'b1, 36'h1);
    end
    // the flag crosses the device irq register, four synchroniser flops and the host irq register, six cycles leave margin
    other_mbox = 1'b1;
    @(negedge mclk_i);
    other_mbox = 1'b0;
    repeat (6) @(negedge mclk_i);
    chk(36'(mailbox_irq_o), 36'h1);
    xfer(1'b0, 1'b0, 15'h7fff, '0, LANES_ALL, 1'b0, '0);
    repeat (6) @(negedge mclk_i);
    chk(36'(mailbox_irq_o), 36'h1);
    xfer(1'b0, 1'b0, 15'h7ffe, '0, LANES_ALL, 1'b0, '0);
    repeat (6) @(negedge mclk_i);
    chk(36'(mailbox_irq_o), 36'h0);
    {retention_i, req_write_i, req_token_i, req_i} = 4'hd;
    repeat (20) begin
      @(negedge mclk_i);
      chk(36'(primary_select_n_o & token_select_n_o & write_strobe_n_o), 36'h1);
    end
    {retention_i, req_i} = 2'h0;
    {slave_role_i, contend} = 2'h3;
    repeat (6) @(negedge mclk_i);
    fork
      xfer(1'b1, 1'b0, a[5], ~d[5], LANES_ALL, 1'b0, '0);
      begin
        repeat (15) @(negedge mclk_i);
        chk(36'(write_strobe_n_o), 36'h1);
        contend = 1'b0;
      end
    join
    xfer(1'b0, 1'b0, a[5], '0, LANES_ALL, 1'b1, ~d[5]);
    slave_role_i = 1'b0;
    chk(36'(viol), 36'h0);
    give_verdict();
  end
endmodule : dpsram_host_test
